// File: inc/rfs_pkg.sv
// Constants, types and notes for the slave identity and trigger register block
// ============================================================================
package rfs_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [4:0] ADDR_SWITCH       = 5'h00;
    localparam logic [4:0] ADDR_TRIG_CTRL    = 5'h1C;
    localparam logic [4:0] ADDR_MAKER_ID     = 5'h1E;
    localparam logic [4:0] ADDR_MAKER_SLAVE  = 5'h1F;

    // ========================================================================
    // Field positions
    localparam int PWR_LSB   = 6;
    localparam int MASK_LSB  = 3;
    localparam int FIRE_LSB  = 0;
    localparam int MAKER_LSB = 4;
    localparam int SID_LSB   = 0;

    // ========================================================================
    // Reset values; maker codes are arbitrary
    localparam logic [3:0] SLAVE_ID_RST  = 4'hA;
    localparam logic [2:0] MASK_RST      = 3'h0;
    localparam logic [1:0] PWR_RST       = 2'h0;
    localparam logic [7:0] SWITCH_RST    = 8'h00;
    localparam logic [7:0] MAKER_CODE    = 8'h3C;
    localparam logic [1:0] MAKER_CODE_LO = 2'h2;

    // ========================================================================
    // Frame layout
    localparam logic [3:0] HDR_BITS  = 4'hD;
    localparam logic [3:0] DATA_BITS = 4'h9;
    localparam logic [3:0] BCAST_ID  = 4'h0;
    localparam logic [2:0] CMD_WRITE = 3'h2;
    localparam logic [2:0] CMD_READ  = 3'h3;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_HDR   = 3'b001,
        S_WDATA = 3'b010,
        S_WPARK = 3'b011,
        S_RTA   = 3'b100,
        S_RDATA = 3'b101,
        S_RPARK = 3'b110
    } rfs_state_t;

endpackage

// File: logic/rfs_link_sampler.sv
// Serial link sampler: synchronisers, clock edges and sequence start
`timescale 1ns/1ns
`default_nettype none
module rfs_link_sampler (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic sclk,
    input  wire logic sdata_in,
    output logic      sclk_rise,
    output logic      sclk_fall,
    output logic      sdata_s,
    output logic      seq_start
);
    logic [1:0] sclk_sync_q;
    logic [1:0] sdata_sync_q;
    logic       sclk_prev_q;
    logic       sdata_prev_q;

    // ========================================================================
    // Two-stage synchronisers; only stage two feeds logic
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_sync_q  <= 2'h0;
            sdata_sync_q <= 2'h0;
            sclk_prev_q  <= 1'b0;
            sdata_prev_q <= 1'b0;
        end else begin
            sclk_sync_q  <= {sclk_sync_q[0], sclk};
            sdata_sync_q <= {sdata_sync_q[0], sdata_in};
            sclk_prev_q  <= sclk_sync_q[1];
            sdata_prev_q <= sdata_sync_q[1];
        end
    end

    assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
    assign sclk_fall = ~sclk_sync_q[1] & sclk_prev_q;
    assign sdata_s   = sdata_sync_q[1];
    // Data only moves with the clock high, so a falling data edge under a
    // steady low clock can only be the start pulse
    assign seq_start = ~sclk_sync_q[1] & ~sclk_prev_q & sdata_prev_q & ~sdata_sync_q[1];
endmodule
`default_nettype wire

// File: logic/rfs_id_trig_regs.sv
// Slave identity registers and trigger logic behind the serial link
`timescale 1ns/1ns
`default_nettype none
module rfs_id_trig_regs
    import rfs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       sdata_in,
    output logic            sdata_out,
    output logic            sdata_oe_n,
    output logic [7:0]      switch_ctrl,
    output logic [1:0]      power_mode
);
    import rfs_pkg::*;

    logic        sclk_rise;
    logic        sclk_fall;
    logic        sdata_s;
    logic        seq_start;
    rfs_state_t  state_q;
    logic [3:0]  cnt_q;
    logic [12:0] sh_q;
    logic [4:0]  addr_q;
    logic [7:0]  data_q;
    logic [8:0]  rd_sh_q;
    logic [3:0]  sid_q;
    logic [2:0]  mask_q;
    logic [1:0]  pwr_q;
    logic [7:0]  shadow_q;
    logic [7:0]  dest_q;
    logic        sdata_out_q;
    logic        sdata_oe_n_q;

    rfs_link_sampler u_sampler (
        .core_clk  (core_clk),
        .rst       (rst),
        .sclk      (sclk),
        .sdata_in  (sdata_in),
        .sclk_rise (sclk_rise),
        .sclk_fall (sclk_fall),
        .sdata_s   (sdata_s),
        .seq_start (seq_start)
    );

    function automatic logic [7:0] read_value(input logic [4:0] a, input logic [1:0] p,
                                               input logic [2:0] m, input logic [3:0] s,
                                               input logic [7:0] d);
        case (a)
            ADDR_SWITCH:      read_value = d;
            ADDR_TRIG_CTRL:   read_value = {p, m, 3'h0};
            ADDR_MAKER_ID:    read_value = MAKER_CODE;
            ADDR_MAKER_SLAVE: read_value = {2'h0, MAKER_CODE_LO, s};
            default:          read_value = 8'h00;
        endcase
    endfunction

    // ========================================================================
    // Frame decode
    logic [12:0] word;
    logic        hdr_done;
    logic        data_done;
    logic        hdr_ok;
    logic [7:0]  cmd;
    logic        commit;
    logic [7:0]  rd_val;

    assign word      = {sh_q[11:0], sdata_s};
    assign hdr_done  = (state_q == S_HDR) && sclk_fall && (cnt_q == HDR_BITS - 4'h1);
    assign data_done = (state_q == S_WDATA) && sclk_fall && (cnt_q == DATA_BITS - 4'h1);
    assign cmd       = word[8:1];
    // Broadcast id may write but never read
    assign hdr_ok    = (^word) && ((word[12:9] == sid_q) ||
                       ((word[12:9] == BCAST_ID) && (cmd[7:5] != CMD_READ)));
    // Writes take effect in the bus park cycle that closes the sequence
    assign commit    = (state_q == S_WPARK) && sclk_fall;
    assign rd_val    = read_value(cmd[4:0], pwr_q, mask_q, sid_q, dest_q);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 13'h0000;
            addr_q  <= 5'h00;
            data_q  <= 8'h00;
            rd_sh_q <= 9'h000;
        end else if (seq_start) begin
            state_q <= S_HDR;
            cnt_q   <= 4'h0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    cnt_q <= 4'h0;
                end
                S_HDR: begin
                    if (sclk_fall) begin
                        sh_q  <= word;
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (hdr_done) begin
                        cnt_q <= 4'h0;
                        if (!hdr_ok) begin
                            state_q <= S_IDLE;
                        end else if (cmd[7]) begin
                            addr_q  <= ADDR_SWITCH;
                            data_q  <= {1'b0, cmd[6:0]};
                            state_q <= S_WPARK;
                        end else if (cmd[7:5] == CMD_WRITE) begin
                            addr_q  <= cmd[4:0];
                            state_q <= S_WDATA;
                        end else if (cmd[7:5] == CMD_READ) begin
                            addr_q  <= cmd[4:0];
                            rd_sh_q <= {rd_val, ~^rd_val};
                            state_q <= S_RTA;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_WDATA: begin
                    if (sclk_fall) begin
                        sh_q  <= word;
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (data_done) begin
                        data_q  <= word[8:1];
                        state_q <= (^word[8:0]) ? S_WPARK : S_IDLE;
                    end
                end
                S_WPARK: begin
                    if (sclk_fall) begin
                        state_q <= S_IDLE;
                    end
                end
                S_RTA: begin
                    if (sclk_rise) begin
                        state_q <= S_RDATA;
                    end
                end
                S_RDATA: begin
                    if (sclk_rise) begin
                        if (cnt_q == DATA_BITS) begin
                            state_q <= S_RPARK;
                        end else begin
                            rd_sh_q <= {rd_sh_q[7:0], 1'b0};
                            cnt_q   <= cnt_q + 4'h1;
                        end
                    end
                end
                S_RPARK: begin
                    if (sclk_fall) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ========================================================================
    // Data pin drive: slave launches on the rising clock edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sdata_out_q  <= 1'b0;
            sdata_oe_n_q <= 1'b1;
        end else if (seq_start || (state_q == S_RPARK && sclk_fall)) begin
            sdata_out_q  <= 1'b0;
            sdata_oe_n_q <= 1'b1;
        end else if (state_q == S_RDATA && sclk_rise) begin
            sdata_out_q  <= (cnt_q == DATA_BITS) ? 1'b0 : rd_sh_q[8];
            sdata_oe_n_q <= 1'b0;
        end
    end

    // ========================================================================
    // Register writes and triggers
    logic       wr_trig;
    logic       wr_sw;
    logic       wr_sid;
    logic [2:0] fire;
    logic       all_blocked;

    assign wr_trig     = commit && (addr_q == ADDR_TRIG_CTRL);
    assign wr_sw       = commit && (addr_q == ADDR_SWITCH);
    assign wr_sid      = commit && (addr_q == ADDR_MAKER_SLAVE);
    // Block bits written in the same command already gate its fire bits
    assign fire        = wr_trig ? (data_q[FIRE_LSB +: 3] & ~data_q[MASK_LSB +: 3]) : 3'h0;
    assign all_blocked = &mask_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_q <= MASK_RST;
            pwr_q  <= PWR_RST;
        end else if (wr_trig) begin
            mask_q <= data_q[MASK_LSB +: 3];
            pwr_q  <= data_q[PWR_LSB +: 2];
        end
    end

    // Identifier changes only at sequence end, so matching uses it next time
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sid_q <= SLAVE_ID_RST;
        end else if (wr_sid) begin
            sid_q <= data_q[SID_LSB +: 4];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shadow_q <= SWITCH_RST;
            dest_q   <= SWITCH_RST;
        end else begin
            if (wr_sw) begin
                shadow_q <= data_q;
            end
            if (wr_sw && all_blocked) begin
                dest_q <= data_q;
            end else if (|fire) begin
                dest_q <= shadow_q;
            end
        end
    end

    assign sdata_out   = sdata_out_q;
    assign sdata_oe_n  = sdata_oe_n_q;
    assign switch_ctrl = dest_q;
    assign power_mode  = pwr_q;

    // ========================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_trig_write_unblocked;
        wr_trig && ((data_q[2:0] & ~data_q[5:3]) != 3'h0);
    endsequence

    sequence s_sid_write;
        (state_q == S_WPARK) && (addr_q == ADDR_MAKER_SLAVE) ##0 sclk_fall;
    endsequence

    a_sid_program: assert property (s_sid_write |=> sid_q == $past(data_q[3:0]))
        else $error("slave id not reprogrammed");
    a_single_trig_load: assert property (s_trig_write_unblocked ##0
        $onehot(data_q[2:0] & ~data_q[5:3]) |=> dest_q == $past(shadow_q))
        else $error("single trigger did not load shadow");
    a_blocked_trig_none: assert property (wr_trig && ((data_q[2:0] & ~data_q[5:3]) == 3'h0)
        |=> $stable(dest_q))
        else $error("blocked trigger moved data");
    a_multi_trig_load: assert property (s_trig_write_unblocked ##0
        ($countones(data_q[2:0] & ~data_q[5:3]) > 1) |=> dest_q == $past(shadow_q))
        else $error("multiple triggers did not load shadow");
    a_shadow_held: assert property (wr_sw && !(&mask_q) |=> $stable(dest_q) ##0
        shadow_q == $past(data_q))
        else $error("write bypassed shadow while a trigger was open");
    a_direct_write: assert property ((state_q == S_WPARK) && (addr_q == ADDR_SWITCH) && (&mask_q)
        ##0 sclk_fall |=> dest_q == $past(data_q) ##1 state_q == S_IDLE || seq_start)
        else $error("blocked write did not reach destination at sequence end");
    a_mask_fields: assert property (wr_trig |=> mask_q == $past(data_q[5:3]) &&
        pwr_q == $past(data_q[7:6]))
        else $error("block bits misplaced");
    a_fire_bit_two: assert property (wr_trig && data_q[2] && !data_q[5]
        |=> dest_q == $past(shadow_q))
        else $error("trigger two did not fire");
    a_sid_frame_stable: assert property ((state_q != S_WPARK) |=> $stable(sid_q))
        else $error("slave id changed mid sequence");
    a_read_drive: assert property ((state_q == S_RDATA) && sclk_rise |=> !sdata_oe_n_q)
        else $error("read data not driven");
endmodule
`default_nettype wire

// File: verif/rfs_link_master.sv
// Behavioural serial link master for the slave identity and trigger block
`timescale 1ns/1ns
`default_nettype none
module rfs_link_master (
    input  wire logic core_clk,
    input  wire logic sdata_out,
    input  wire logic sdata_oe_n,
    output logic      sclk,
    output logic      sdata_line
);
    logic m_en;
    logic m_d;
    logic hold_q = 1'b0;

    // ========================================================================
    // Wire level
    // No keeper modelled: a released line shows the inverse of its last level
    assign sdata_line = !sdata_oe_n ? sdata_out : (m_en ? m_d : ~hold_q);

    always @(posedge core_clk) begin
        if (m_en || !sdata_oe_n) begin
            hold_q <= sdata_line;
        end
    end

    initial begin
        sclk = 1'b0;
        m_en = 1'b1;
        m_d = 1'b0;
    end

    // ========================================================================
    // Frames
    // Data changes with the rising clock, slave samples on the fall
    task automatic send_bit(input logic b);
        sclk = 1'b1;
        m_d = b;
        #160;
        sclk = 1'b0;
        #160;
    endtask

    task automatic header(input logic [3:0] sa, input logic [7:0] cmd, input logic bad);
        logic [11:0] v;
        v = {sa, cmd};
        m_en = 1'b1;
        m_d = 1'b1;
        #120;
        m_d = 1'b0;
        #120;
        for (int i = 11; i >= 0; i--) begin
            send_bit(v[i]);
        end
        send_bit(~^v ^ bad);
    endtask

    task automatic write_reg(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d, input logic bad);
        header(sa, {3'h2, a}, bad);
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i]);
        end
        send_bit(~^d);
        send_bit(1'b0);
        #240;
    endtask

    // Short form: seven data bits ride in the command, then bus park
    task automatic write_short(input logic [3:0] sa, input logic [6:0] d);
        header(sa, {1'b1, d}, 1'b0);
        send_bit(1'b0);
        #240;
    endtask

    task automatic read_reg(input logic [3:0] sa, input logic [4:0] a, output logic [7:0] d,
                            output logic par, output logic drv);
        logic [8:0] v;
        drv = 1'b0;
        header(sa, {3'h3, a}, 1'b0);
        send_bit(1'b0);
        m_en = 1'b0;
        for (int i = 8; i >= 0; i--) begin
            sclk = 1'b1;
            #160;
            sclk = 1'b0;
            #80;
            v[i] = sdata_line;
            drv = drv | !sdata_oe_n;
            #80;
        end
        sclk = 1'b1;
        #160;
        sclk = 1'b0;
        #240;
        m_en = 1'b1;
        m_d = 1'b0;
        d = v[8:1];
        par = v[0];
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the slave identity and trigger register block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import rfs_pkg::*;

    typedef struct packed {
        logic [1:0] pwr;
        logic [2:0] mask;
        logic [2:0] fire;
        logic [7:0] d;
        logic [7:0] ew;
        logic [7:0] ef;
    } rfs_row_t;

    logic       core_clk;
    logic       rst;
    logic       sclk;
    logic       sdata_line;
    logic       sdata_out;
    logic       sdata_oe_n;
    logic [7:0] switch_ctrl;
    logic [1:0] power_mode;
    logic [7:0] rv;
    logic       par;
    logic       drv;
    int         miscompares;
    int         checks;

    // Rows run in order: each expected value assumes the rows before it
    localparam rfs_row_t ROWS [8] = '{
        '{2'h1, 3'h0, 3'h1, 8'h11, 8'h00, 8'h11},
        '{2'h2, 3'h0, 3'h2, 8'h22, 8'h11, 8'h22},
        '{2'h0, 3'h0, 3'h4, 8'h33, 8'h22, 8'h33},
        '{2'h1, 3'h1, 3'h1, 8'h44, 8'h33, 8'h33},
        '{2'h2, 3'h1, 3'h6, 8'h55, 8'h33, 8'h55},
        '{2'h0, 3'h6, 3'h7, 8'h66, 8'h55, 8'h66},
        '{2'h1, 3'h7, 3'h7, 8'h77, 8'h77, 8'h77},
        '{2'h2, 3'h3, 3'h3, 8'h88, 8'h77, 8'h77}
    };

    rfs_id_trig_regs dut (
        .core_clk    (core_clk),
        .rst         (rst),
        .sclk        (sclk),
        .sdata_in    (sdata_line),
        .sdata_out   (sdata_out),
        .sdata_oe_n  (sdata_oe_n),
        .switch_ctrl (switch_ctrl),
        .power_mode  (power_mode)
    );

    rfs_link_master mst (
        .core_clk   (core_clk),
        .sdata_out  (sdata_out),
        .sdata_oe_n (sdata_oe_n),
        .sclk       (sclk),
        .sdata_line (sdata_line)
    );

    always #20 core_clk = ~core_clk;

    // ========================================================================
    // Checking and closing
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(negedge core_clk);
        rst = 1'b1;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask

    // Read with parity, drive and release of the data line checked too
    task automatic rd_chk(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] exp, input string name);
        mst.read_reg(sa, a, rv, par, drv);
        chk(name, rv, exp);
        chk("read_parity", {7'h0, par}, {7'h0, ~^exp});
        chk("read_driven", {7'h0, drv}, 8'h01);
        chk("oe_released", {7'h0, sdata_oe_n}, 8'h01);
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        miscompares = 0;
        checks = 0;
        do_reset();
        chk("switch_rst", switch_ctrl, SWITCH_RST);
        chk("power_rst", {6'h0, power_mode}, {6'h0, PWR_RST});
        rd_chk(4'hA, ADDR_MAKER_SLAVE, {2'h0, MAKER_CODE_LO, SLAVE_ID_RST}, "id_rst");
        rd_chk(4'hA, ADDR_TRIG_CTRL, 8'h00, "trig_rst");
        for (int r = 0; r < 8; r++) begin
            mst.write_reg(4'hA, ADDR_TRIG_CTRL, {ROWS[r].pwr, ROWS[r].mask, 3'h0}, 1'b0);
            mst.write_reg(4'hA, ADDR_SWITCH, ROWS[r].d, 1'b0);
            chk("switch_written", switch_ctrl, ROWS[r].ew);
            mst.write_reg(4'hA, ADDR_TRIG_CTRL, {ROWS[r].pwr, ROWS[r].mask, ROWS[r].fire}, 1'b0);
            chk("switch_fired", switch_ctrl, ROWS[r].ef);
            chk("power_mode", {6'h0, power_mode}, {6'h0, ROWS[r].pwr});
            rd_chk(4'hA, ADDR_TRIG_CTRL, {ROWS[r].pwr, ROWS[r].mask, 3'h0}, "trig_read");
        end
        // Corrupted frame must leave the destination alone
        mst.write_reg(4'hA, ADDR_TRIG_CTRL, 8'h38, 1'b0);
        mst.write_reg(4'hA, ADDR_SWITCH, 8'hAB, 1'b1);
        chk("switch_bad_parity", switch_ctrl, 8'h77);
        mst.write_reg(4'hA, ADDR_SWITCH, 8'hAB, 1'b0);
        chk("switch_direct", switch_ctrl, 8'hAB);
        mst.write_short(4'hA, 7'h5A);
        chk("switch_short_write", switch_ctrl, 8'h5A);
        rd_chk(4'hA, ADDR_MAKER_ID, MAKER_CODE, "maker_code");
        mst.write_reg(4'hA, ADDR_MAKER_ID, 8'hFF, 1'b0);
        rd_chk(4'hA, ADDR_MAKER_ID, MAKER_CODE, "maker_code_ro");
        mst.write_reg(4'hA, ADDR_MAKER_SLAVE, 8'h05, 1'b0);
        mst.read_reg(4'hA, ADDR_MAKER_SLAVE, rv, par, drv);
        chk("old_id_refused", {7'h0, drv}, 8'h00);
        mst.read_reg(4'h0, ADDR_MAKER_SLAVE, rv, par, drv);
        chk("bcast_read_refused", {7'h0, drv}, 8'h00);
        rd_chk(4'h5, ADDR_MAKER_SLAVE, {2'h0, MAKER_CODE_LO, 4'h5}, "new_id");
        rd_chk(4'h5, 5'h05, 8'h00, "unmapped_read");
        // Second reset in mid-run restores identifier and block bits
        do_reset();
        chk("switch_rst2", switch_ctrl, SWITCH_RST);
        rd_chk(4'hA, ADDR_MAKER_SLAVE, {2'h0, MAKER_CODE_LO, SLAVE_ID_RST}, "id_rst2");
        rd_chk(4'hA, ADDR_TRIG_CTRL, 8'h00, "trig_rst2");
        complete_run();
    end

    // A hung link ends the run through the same closing task
    initial begin
        #1_000_000;
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
